/* File: hdl/csf_regs.svh */
// Register offsets, field positions and reset values of the charger
// status and event flag bank.
// Assumes inclusion by bare name from design or bench files.
//
// Function
// - Ext clock pin state field at bits 5:4; 00 none, 01 valid, 10 fault.
// - Bit 2 of third status shows backward power mode on.
// - Fault bit 7 follows input under-voltage protection.
// - Fault bit 6 follows input over-voltage protection.
// - Fault bit 5 follows battery over-current detection.
// - Fault bit 4 follows battery over-voltage protection.
// - Fault bit 3 follows thermal shutdown protection.
// - Fault bit 2 follows charge safety timer expiry.
// - Fault bit 1 gate supply bad; forced one in battery-only mode.
// - Flag one bit 7 latches one-shot conversion done; a read clears it outside continuous conversion mode.
// - Conversion done flag reads zero in continuous conversion mode.
// - Flag one bit 6 latches entry to input current regulation.
// - Flag one bit 5 latches entry to input voltage regulation.
// - Flag one bit 3 latches watchdog expiry rise; resets to one.
// - Flag one bit 0 latches any charge-cycle state change.
// - Flag two bit 7 latches any toggle of input power good.
// - Flag two bit 4 latches any thermistor zone code change.
// - Flag two bit 3 latches any backward mode toggle.
// - Flag two bit 1 latches any ext clock pin state change.
// - Charge-cycle state is a three-bit code; changes feed its flag.
// - Thermistor zone is a three-bit code; changes feed its flag.
// - Watchdog expired status rising edge drives the watchdog flag.
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH
`define CSF_OFS_STAT3    8'h23
`define CSF_OFS_FAULT    8'h24
`define CSF_OFS_FLAG1    8'h25
`define CSF_OFS_FLAG2    8'h26
`define CSF_RST_STAT3    8'h00
`define CSF_RST_FAULT    8'h00
`define CSF_RST_FLAG1    8'h08
`define CSF_RST_FLAG2    8'h00
`define CSF_F1_CONV_DONE 7
`define CSF_F1_ICL       6
`define CSF_F1_VLIM      5
`define CSF_F1_WDOG      3
`define CSF_F1_CHARGE    0
`define CSF_F2_PGOOD     7
`define CSF_F2_TZONE     4
`define CSF_F2_REVERSE   3
`define CSF_F2_CLKPIN    1
`define CSF_S3_REVERSE   2
`endif

/* File: hdl/csf_pkg.sv */
// Types shared by the status and flag bank and its bench.
// Assumes the register constants come from csf_regs.svh.
package csf_pkg;

	typedef struct packed {
		logic [1:0] ext_clock_pin_state;
		logic       reverse_mode_on;
		logic       input_undervoltage_active;
		logic       input_overvoltage_active;
		logic       battery_overcurrent_active;
		logic       battery_overvoltage_active;
		logic       thermal_shutdown_active;
		logic       safety_timer_expired;
		logic       gate_supply_bad;
		logic       battery_only_conv_off;
		logic       adc_oneshot_done;
		logic       adc_continuous;
		logic       input_current_limit_active;
		logic       input_voltage_limit_active;
		logic       watchdog_expired;
		logic [2:0] charge_cycle_state;
		logic       input_power_good;
		logic [2:0] thermistor_zone_code;
	} csf_core_type;

	typedef struct packed {
		logic       commit;
		logic       fetch;
		logic [7:0] addr;
	} csf_req_type;

	typedef enum logic [2:0] {
		st_idle  = 3'h0,
		st_addr  = 3'h1,
		st_a_ack = 3'h3,
		st_fetch = 3'h2,
		st_tx    = 3'h6,
		st_t_ack = 3'h7,
		st_rx    = 3'h5,
		st_r_ack = 3'h4
	} csf_state_type;

endpackage

/* File: hdl/csf_status_flags.sv */
// Status and clear-on-read event flags behind the two-wire host port.
// Assumes core signals are synchronous to clk_sys and clk_link is a
// free-running oversampling clock for the serial pins.
`timescale 1ns/1ps
`include "csf_regs.svh"

module csf_status_flags #(
	parameter logic [6:0] DEV_ADDR = 7'h5a // Arbitrary value
) (
	// System side
	input  logic                  clk_sys,
	input  logic                  reset,
	input  csf_pkg::csf_core_type core_in,
	// Serial host link
	input  logic                  clk_link,
	input  logic                  scl_in,
	input  logic                  sda_in,
	output logic                  sda_out,
	output logic                  sda_oe
);

	if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_bad_addr
		$error("Device address is reserved");
	end

	////////////////////////////////////////////////////////////////////
	// Declarations of both domains
	csf_pkg::csf_core_type  prev_reg;
	csf_pkg::csf_req_type   req_reg;
	csf_pkg::csf_state_type state_reg;
	logic [7:0]             stat3_reg, fault_reg, flag1_reg, flag2_reg;
	logic [7:0]             flag1_next, flag2_next, set1, set2;
	logic [7:0]             clr1, clr2, snap_reg, snap_addr_reg;
	logic [7:0]             rd_data_reg, rd_value, shift_reg, ptr_reg;
	logic [3:0]             cnt_reg;
	logic                   primed_reg, req_ev, req_tgl_reg, ack_tgl_reg;
	logic                   req_s1_reg, req_s2_reg, req_s3_reg;
	logic                   rst_l1_reg, rst_l2_reg, ack_s1_reg, ack_s2_reg;
	logic                   scl_s1_reg, scl_s2_reg, scl_s3_reg;
	logic                   sda_s1_reg, sda_s2_reg, sda_s3_reg;
	logic                   oe_reg, rw_reg, first_reg, nack_reg;
	logic                   scl_rise, scl_fall, start_det, stop_det;
	logic                   pending;

	////////////////////////////////////////////////////////////////////
	// Live status
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stat3_reg <= `CSF_RST_STAT3;
			fault_reg <= `CSF_RST_FAULT;
		end else begin
			stat3_reg <= {2'b00, core_in.ext_clock_pin_state,
				1'b0, core_in.reverse_mode_on, 2'b00};
			fault_reg <= {
				core_in.input_undervoltage_active,
				core_in.input_overvoltage_active,
				core_in.battery_overcurrent_active,
				core_in.battery_overvoltage_active,
				core_in.thermal_shutdown_active,
				core_in.safety_timer_expired,
				core_in.gate_supply_bad |
					core_in.battery_only_conv_off,
				1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Event detection
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prev_reg   <= '0;
			primed_reg <= 1'b0;
		end else begin
			prev_reg   <= core_in;
			primed_reg <= 1'b1;
		end
	end

	always_comb begin
		set1 = 8'h00;
		set2 = 8'h00;
		if (primed_reg) begin
			set1[`CSF_F1_CONV_DONE] = core_in.adc_oneshot_done &
				~core_in.adc_continuous;
			set1[`CSF_F1_ICL] = core_in.input_current_limit_active &
				~prev_reg.input_current_limit_active;
			set1[`CSF_F1_VLIM] = core_in.input_voltage_limit_active &
				~prev_reg.input_voltage_limit_active;
			set1[`CSF_F1_WDOG] = core_in.watchdog_expired &
				~prev_reg.watchdog_expired;
			set1[`CSF_F1_CHARGE] = core_in.charge_cycle_state !=
				prev_reg.charge_cycle_state;
			set2[`CSF_F2_PGOOD] = core_in.input_power_good !=
				prev_reg.input_power_good;
			set2[`CSF_F2_TZONE] = core_in.thermistor_zone_code !=
				prev_reg.thermistor_zone_code;
			set2[`CSF_F2_REVERSE] = core_in.reverse_mode_on !=
				prev_reg.reverse_mode_on;
			set2[`CSF_F2_CLKPIN] = core_in.ext_clock_pin_state !=
				prev_reg.ext_clock_pin_state;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Clear on completed read
	always_comb begin
		clr1 = 8'h00;
		clr2 = 8'h00;
		if (req_ev && req_reg.commit) begin
			if (snap_addr_reg == `CSF_OFS_FLAG1) begin
				clr1 = snap_reg;
			end
			if (snap_addr_reg == `CSF_OFS_FLAG2) begin
				clr2 = snap_reg;
			end
		end
		flag1_next = (flag1_reg & ~clr1) | set1;
		flag2_next = (flag2_reg & ~clr2) | set2;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flag1_reg <= `CSF_RST_FLAG1;
			flag2_reg <= `CSF_RST_FLAG2;
		end else begin
			flag1_reg <= flag1_next;
			flag2_reg <= flag2_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data and handshake toward the link
	always_comb begin
		unique case (req_reg.addr)
			`CSF_OFS_STAT3: rd_value = stat3_reg;
			`CSF_OFS_FAULT: rd_value = fault_reg;
			`CSF_OFS_FLAG1: rd_value = {flag1_reg[7] &
				~core_in.adc_continuous, flag1_reg[6:0]};
			`CSF_OFS_FLAG2: rd_value = flag2_reg;
			default:        rd_value = 8'h00;
		endcase
	end

	assign req_ev = req_s2_reg ^ req_s3_reg;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ack_tgl_reg   <= 1'b0;
			rd_data_reg   <= 8'h00;
			snap_reg      <= 8'h00;
			snap_addr_reg <= 8'h00;
		end else if (req_ev) begin
			ack_tgl_reg <= ~ack_tgl_reg;
			if (req_reg.fetch) begin
				rd_data_reg   <= rd_value;
				snap_reg      <= rd_value;
				snap_addr_reg <= req_reg.addr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Link domain synchronisers
	always_ff @(posedge clk_link) begin
		rst_l1_reg <= reset;
		rst_l2_reg <= rst_l1_reg;
		sda_out    <= 1'b0;
	end

	always_ff @(posedge clk_link) begin
		if (rst_l2_reg) begin
			{scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'b111;
			{sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'b111;
			{ack_s1_reg, ack_s2_reg}             <= 2'b00;
		end else begin
			{scl_s1_reg, scl_s2_reg, scl_s3_reg} <=
				{scl_in, scl_s1_reg, scl_s2_reg};
			{sda_s1_reg, sda_s2_reg, sda_s3_reg} <=
				{sda_in, sda_s1_reg, sda_s2_reg};
			{ack_s1_reg, ack_s2_reg}             <=
				{ack_tgl_reg, ack_s1_reg};
		end
	end

	assign scl_rise  = scl_s2_reg & ~scl_s3_reg;
	assign scl_fall  = ~scl_s2_reg & scl_s3_reg;
	assign start_det = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
	assign stop_det  = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
	assign pending   = req_tgl_reg != ack_s2_reg;

	////////////////////////////////////////////////////////////////////
	// Two-wire slave
	always_ff @(posedge clk_link) begin
		if (rst_l2_reg) begin
			state_reg   <= csf_pkg::st_idle;
			cnt_reg     <= 4'h0;
			shift_reg   <= 8'h00;
			ptr_reg     <= 8'h00;
			oe_reg      <= 1'b0;
			rw_reg      <= 1'b0;
			first_reg   <= 1'b0;
			nack_reg    <= 1'b0;
			req_tgl_reg <= 1'b0;
			req_reg     <= '0;
		end else if (stop_det) begin
			state_reg <= csf_pkg::st_idle;
			oe_reg    <= 1'b0;
		end else if (start_det) begin
			state_reg <= csf_pkg::st_addr;
			cnt_reg   <= 4'h0;
			oe_reg    <= 1'b0;
		end else begin
			unique case (state_reg)
				csf_pkg::st_idle: begin
				end
				csf_pkg::st_addr: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s2_reg};
						cnt_reg   <= cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == 4'h8) begin
						cnt_reg <= 4'h0;
						if (shift_reg[7:1] == DEV_ADDR) begin
							oe_reg    <= 1'b1;
							rw_reg    <= shift_reg[0];
							first_reg <= 1'b1;
							state_reg <= csf_pkg::st_a_ack;
						end else begin
							state_reg <= csf_pkg::st_idle;
						end
					end
				end
				csf_pkg::st_a_ack: begin
					if (scl_fall) begin
						oe_reg <= 1'b0;
						if (rw_reg) begin
							req_reg     <= '{1'b0, 1'b1, ptr_reg};
							req_tgl_reg <= ~req_tgl_reg;
							state_reg   <= csf_pkg::st_fetch;
						end else begin
							state_reg <= csf_pkg::st_rx;
						end
					end
				end
				csf_pkg::st_fetch: begin
					if (!pending) begin
						shift_reg <= {rd_data_reg[6:0], 1'b0};
						oe_reg    <= ~rd_data_reg[7];
						cnt_reg   <= 4'h0;
						state_reg <= csf_pkg::st_tx;
					end
				end
				csf_pkg::st_tx: begin
					if (scl_rise) begin
						cnt_reg <= cnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (cnt_reg == 4'h8) begin
							oe_reg    <= 1'b0;
							state_reg <= csf_pkg::st_t_ack;
						end else begin
							oe_reg    <= ~shift_reg[7];
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
					end
				end
				csf_pkg::st_t_ack: begin
					if (scl_rise) begin
						req_reg <= '{1'b1, ~sda_s2_reg,
							ptr_reg + 8'h01};
						req_tgl_reg <= ~req_tgl_reg;
						ptr_reg     <= ptr_reg + 8'h01;
						nack_reg    <= sda_s2_reg;
					end else if (scl_fall) begin
						state_reg <= nack_reg ? csf_pkg::st_idle :
							csf_pkg::st_fetch;
					end
				end
				csf_pkg::st_rx: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s2_reg};
						cnt_reg   <= cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == 4'h8) begin
						oe_reg    <= 1'b1;
						cnt_reg   <= 4'h0;
						first_reg <= 1'b0;
						state_reg <= csf_pkg::st_r_ack;
						if (first_reg) begin
							ptr_reg <= shift_reg;
						end
						// Data bytes are acknowledged and dropped
					end
				end
				csf_pkg::st_r_ack: begin
					if (scl_fall) begin
						oe_reg    <= 1'b0;
						state_reg <= csf_pkg::st_rx;
					end
				end
			endcase
		end
	end

	assign sda_oe = oe_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_clk_field;
		stat3_reg[5:4] == $past(core_in.ext_clock_pin_state) &&
			stat3_reg[7:6] == 2'b00;
	endproperty
	a_clk_field: assert property (p_clk_field)
		else $error("Clock pin field wrong");

	property p_rev_flag;
		primed_reg && core_in.reverse_mode_on != prev_reg.reverse_mode_on
			|=> flag2_reg[3] && stat3_reg[2] == $past(core_in.reverse_mode_on);
	endproperty
	a_rev_flag: assert property (p_rev_flag)
		else $error("Reverse toggle not latched");

	property p_fault_uv;
		fault_reg[7] == $past(core_in.input_undervoltage_active) &&
			fault_reg[3] == $past(core_in.thermal_shutdown_active);
	endproperty
	a_fault_uv: assert property (p_fault_uv)
		else $error("Fault status mismatch");

	property p_gate;
		core_in.battery_only_conv_off |=> fault_reg[1];
	endproperty
	a_gate: assert property (p_gate)
		else $error("Gate supply bit not forced");

	property p_conv_cont;
		req_ev && req_reg.fetch && req_reg.addr == `CSF_OFS_FLAG1 &&
			core_in.adc_continuous |=> !rd_data_reg[7];
	endproperty
	a_conv_cont: assert property (p_conv_cont)
		else $error("Conversion flag read in continuous mode");

	property p_wdog;
		primed_reg && $rose(core_in.watchdog_expired) |=> flag1_reg[3];
	endproperty
	a_wdog: assert property (p_wdog)
		else $error("Watchdog rise not latched");

	property p_reset_val;
		$fell(reset) |-> flag1_reg == `CSF_RST_FLAG1;
	endproperty
	a_reset_val: assert property (p_reset_val)
		else $error("Flag one reset value wrong");

	property p_set_wins;
		(|(set1 & clr1)) |=> (flag1_reg & $past(set1)) == $past(set1);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("Event lost on clearing read");

	property p_resv;
		flag1_reg[4] == 1'b0 && flag1_reg[2:1] == 2'b00 &&
			flag2_reg[6:5] == 2'b00 && flag2_reg[2] == 1'b0 &&
			flag2_reg[0] == 1'b0 && fault_reg[0] == 1'b0;
	endproperty
	a_resv: assert property (p_resv)
		else $error("Reserved bit set");

	property p_ack;
		req_ev |=> ack_tgl_reg != $past(ack_tgl_reg) ##1 !req_ev;
	endproperty
	a_ack: assert property (p_ack)
		else $error("Request not acknowledged");

	c_fetch: cover property (req_ev && req_reg.fetch);
	c_commit: cover property (req_ev && req_reg.commit && |clr1);
	c_set_wins: cover property (|(set1 & clr1));

endmodule

/* File: sim/csf_host_model.sv */
// Behavioural two-wire host that drives the serial side of the flag bank.
// Assumes an open-drain data wire with pull-up resolved by the bench and
// a clk_link of 125 ns; SCL low lasts 10 link cycles, high 4.
`timescale 1ns/1ps

module csf_host_model (
	// Link clock and resolved data wire
	input  wire logic clk_link,
	input  wire logic sda_line,
	// Host drive, sda_rel high lets the pull-up win
	output logic      scl,
	output logic      sda_rel
);
	localparam int LOW_CYC  = 10;
	localparam int HIGH_CYC = 4;

	initial begin
		scl     = 1'b1;
		sda_rel = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_link);
	endtask

	// One clock pulse; SCL low on entry and on exit
	task automatic bit_io(input logic b, output logic s);
		wait_cyc(4);
		sda_rel <= b;
		wait_cyc(LOW_CYC - 4);
		scl <= 1'b1;
		wait_cyc(HIGH_CYC);
		s = sda_line;
		scl <= 1'b0;
	endtask

	// Start or repeated start; leaves SCL low
	task automatic start_cond();
		wait_cyc(4);
		sda_rel <= 1'b1;
		wait_cyc(LOW_CYC - 4);
		scl <= 1'b1;
		wait_cyc(HIGH_CYC);
		sda_rel <= 1'b0;
		wait_cyc(HIGH_CYC);
		scl <= 1'b0;
	endtask

	// Stop, then bus-free time before any next start
	task automatic stop_cond();
		wait_cyc(4);
		sda_rel <= 1'b0;
		wait_cyc(LOW_CYC - 4);
		scl <= 1'b1;
		wait_cyc(HIGH_CYC);
		sda_rel <= 1'b1;
		wait_cyc(LOW_CYC);
	endtask

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, ack);
	endtask

	// Host acknowledges every byte but the last
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, s);
	endtask
endmodule

/* File: sim/csf_status_flags_tb.sv */
// Self-checking bench for the status and event flag bank.
// Assumes csf_pkg, csf_regs.svh and the host model are compiled first.
`timescale 1ns/1ps
`include "csf_regs.svh"

module csf_status_flags_tb;
	localparam logic [6:0] DEV = 7'h5a; // Arbitrary value

	logic                  clk_sys;
	logic                  clk_link;
	logic                  reset;
	csf_pkg::csf_core_type core;
	logic                  scl;
	logic                  sda_rel;
	logic                  sda_out;
	logic                  sda_oe;
	logic                  sda_line;
	logic [7:0]            rx [0:4];
	int                    err_total;
	int                    checked;

	// Open-drain wire with pull-up
	assign sda_line = sda_rel & (sda_oe ? sda_out : 1'b1);

	csf_status_flags #(.DEV_ADDR(DEV)) i_dut (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.core_in  (core),
		.clk_link (clk_link),
		.scl_in   (scl),
		.sda_in   (sda_line),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe)
	);

	csf_host_model i_host (
		.clk_link (clk_link),
		.sda_line (sda_line),
		.scl      (scl),
		.sda_rel  (sda_rel)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial begin
		clk_link = 1'b0;
		#17;
		forever #62.5 clk_link = ~clk_link;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Pointer write, optional ignored data byte, repeated start, n reads
	task automatic read_regs(input logic [7:0] ptr, input int n,
		input logic junk);
		logic ack;
		i_host.start_cond();
		i_host.put_byte({DEV, 1'b0}, ack);
		chk({7'h00, ack}, 8'h00);
		i_host.put_byte(ptr, ack);
		chk({7'h00, ack}, 8'h00);
		if (junk) begin
			i_host.put_byte(8'hff, ack);
			chk({7'h00, ack}, 8'h00);
		end
		i_host.start_cond();
		i_host.put_byte({DEV, 1'b1}, ack);
		chk({7'h00, ack}, 8'h00);
		for (int i = 0; i < n; i++) begin
			i_host.get_byte(i == n - 1, rx[i]);
		end
		i_host.stop_cond();
	endtask

	// New core levels, done pulse lasts one cycle
	task automatic set_core(input csf_pkg::csf_core_type c);
		@(posedge clk_sys);
		core <= c;
		@(posedge clk_sys);
		core.adc_oneshot_done <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset values, with a data byte that must be dropped
	task automatic sc_reset_values();
		read_regs(`CSF_OFS_STAT3, 4, 1'b1);
		chk(rx[0], 8'h00);
		chk(rx[1], 8'h00);
		chk(rx[2], 8'h08);
		chk(rx[3], 8'h00);
	endtask

	// Every event source fires once, half the faults raised
	task automatic sc_events_latch();
		csf_pkg::csf_core_type c;
		c = core;
		c.ext_clock_pin_state = 2'b01;
		c.reverse_mode_on = 1'b1;
		c.input_undervoltage_active = 1'b1;
		c.battery_overcurrent_active = 1'b1;
		c.thermal_shutdown_active = 1'b1;
		c.gate_supply_bad = 1'b1;
		c.adc_oneshot_done = 1'b1;
		c.input_current_limit_active = 1'b1;
		c.input_voltage_limit_active = 1'b1;
		c.watchdog_expired = 1'b1;
		c.charge_cycle_state = 3'h3;
		c.input_power_good = 1'b1;
		c.thermistor_zone_code = 3'h4;
		set_core(c);
		read_regs(`CSF_OFS_STAT3, 4, 1'b0);
		chk(rx[0], 8'h14);
		chk(rx[1], 8'haa);
		chk(rx[2], 8'he9);
		chk(rx[3], 8'h9a);
	endtask

	// Flags cleared by the last read, other faults, continuous mode
	task automatic sc_clear_and_modes();
		csf_pkg::csf_core_type c;
		c = core;
		c.adc_oneshot_done = 1'b1;
		set_core(c);
		c = core;
		c.ext_clock_pin_state = 2'b10;
		c.reverse_mode_on = 1'b0;
		c.input_undervoltage_active = 1'b0;
		c.input_overvoltage_active = 1'b1;
		c.battery_overcurrent_active = 1'b0;
		c.battery_overvoltage_active = 1'b1;
		c.thermal_shutdown_active = 1'b0;
		c.safety_timer_expired = 1'b1;
		c.gate_supply_bad = 1'b0;
		c.battery_only_conv_off = 1'b1;
		c.adc_continuous = 1'b1;
		c.adc_oneshot_done = 1'b1;
		set_core(c);
		read_regs(`CSF_OFS_STAT3, 5, 1'b0);
		chk(rx[0], 8'h20);
		chk(rx[1], 8'h56);
		chk(rx[2], 8'h00);
		chk(rx[3], 8'h0a);
		chk(rx[4], 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		err_total = 0;
		checked = 0;
		reset = 1'b1;
		core = '0;
		repeat (5) @(posedge clk_sys);
		repeat (3) @(posedge clk_link);
		@(posedge clk_sys);
		reset <= 1'b0;
		repeat (5) @(posedge clk_link);
		sc_reset_values();
		sc_events_latch();
		sc_clear_and_modes();
		end_of_test();
	end

	// Guard against a hung run
	initial begin
		repeat (100000) @(posedge clk_sys);
		err_total++;
		$display("BAD t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
		end_of_test();
	end
endmodule
